// ### design/irq_ctrl_defines.vh
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// register offsets (byte addresses, one word each)
`define OFS_EN_A       8'h00
`define OFS_EN_B       8'h04
`define OFS_PRIO_LO_A  8'h08
`define OFS_PRIO_HI_A  8'h0C
`define OFS_PRIO_LO_B  8'h10
`define OFS_PRIO_HI_B  8'h14
`define OFS_TCTRL      8'h18
`define OFS_STATUS     8'h1C
`define OFS_SVC        8'h20
`define OFS_IRQ_STAT   8'h24
`define OFS_IRQ_MASK   8'h28
`define OFS_PWR        8'h2C

// enable register a: bit 7 is the global enable, bits 6:0 sources 0..6
`define EN_A_GLOBAL    7
// enable register b: bits 4:0 sources 7..11
`define SRC_A_CNT      7
`define SRC_B_CNT      5
// timer control layout
`define TCTRL_IT0      0
`define TCTRL_IT1      2
`define TCTRL_IE0      1
`define TCTRL_IE1      3
// power control bits
`define PWR_IDLE       0
`define PWR_PDOWN      1
// event status bits
`define EV_VECTOR      0
`define EV_WAKE        1
`define EV_EXT0        2
`define EV_EXT1        3
`define EV_W           4

`define NUM_SRC        12
// source indices of the two external inputs
`define SRC_EXT0       4'h0
`define SRC_EXT1       4'h2
`define TOP_LEVEL      2'h3
`define NO_LEVEL       3'h0

`endif

// ### design/irq_ctrl.v
// Design decisions made here: register access over Wishbone and the register offsets.
`include "irq_ctrl_defines.vh"

// Overview of operation
// [R1] arbitrates and nests interrupts across four priority levels
// [R2] accepts twelve request sources, two of them external pins
// [R3] each source has its own enable bit over two enable registers
// [R4] global enable bit in enable register a blocks every source when clear; code gates only grant, not the idle or power-down wake
// [R5] four priority registers give each source one of four levels
// [R6] active routine preempted only by strictly higher priority request
// [R7] routine at top level is never preempted
// [R8] among pending requests the higher priority level wins
// [R9] fixed polling order resolves ties inside one level only
// [R10] each external input selectable level or edge by timer control bit
// [R11] edge mode sets request flag on sampled high followed by low
// [R12] enabled external interrupt wakes from idle or power-down
// [R13] any enabled source ends idle mode
// [R14] level request follows low pin; edge flag cleared on vector taken
// [R15] level is high-register bit over low-register bit
module irq_ctrl #(
   parameter NSRC = 12
) (
   input wire clk,
   input wire srst,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg wb_ack_o,
   input wire [1:0] ext_irq_pin,
   input wire [NSRC-1:0] src_req,
   input wire vec_ack,
   input wire reti,
   output reg irq_req_q,
   output reg [3:0] irq_vec_q,
   output reg wake_q,
   output reg irq_q
);

   reg [7:0] irq_enable_reg_a;
   reg [7:0] irq_enable_reg_b;
   reg [7:0] prio_low_reg_a;
   reg [7:0] prio_high_reg_a;
   reg [7:0] prio_low_reg_b;
   reg [7:0] prio_high_reg_b;
   reg [7:0] timer_control_reg;
   reg [1:0] pwr_q;
   reg [`EV_W-1:0] ev_stat_q;
   reg [`EV_W-1:0] ev_mask_q;
   // one bit per level in service, nested routines stack naturally
   reg [3:0] in_svc_q;
   reg [1:0] pin_s1_q;
   reg [1:0] pin_s2_q;
   reg [1:0] pin_prev_q;

   wire [1:0] ext_irq_trigger_type;
   wire [1:0] ext_irq_request_flag;
   wire global_irq_enable;
   assign ext_irq_trigger_type = {timer_control_reg[`TCTRL_IT1], timer_control_reg[`TCTRL_IT0]};
   assign ext_irq_request_flag = {timer_control_reg[`TCTRL_IE1], timer_control_reg[`TCTRL_IE0]};
   assign global_irq_enable = irq_enable_reg_a[`EN_A_GLOBAL];

   // byte lane write helper
   function [7:0] lane_wr;
      input [7:0] old;
      input [31:0] dat;
      input [3:0] sel;
      begin
         lane_wr = sel[0] ? dat[7:0] : old;
      end
   endfunction

   // highest set bit of the in-service vector, plus one; zero when idle
   function [2:0] svc_level;
      input [3:0] v;
      begin
         if (v[3])
            svc_level = 3'h4;
         else if (v[2])
            svc_level = 3'h3;
         else if (v[1])
            svc_level = 3'h2;
         else if (v[0])
            svc_level = 3'h1;
         else
            svc_level = `NO_LEVEL;
      end
   endfunction

   // two-bit level of one source, high-register bit on top
   function [1:0] prio_of;
      input [NSRC-1:0] hi;
      input [NSRC-1:0] lo;
      input [3:0] idx;
      begin
         prio_of = {hi[idx], lo[idx]}; // R15
      end
   endfunction

   // request lines; external sources replace src_req bits 0 and 2
   reg [NSRC-1:0] req_raw;
   reg [NSRC-1:0] en_all;
   reg [NSRC-1:0] plo_all;
   reg [NSRC-1:0] phi_all;
   reg [NSRC-1:0] pend;
   integer i;
   always @* begin
      req_raw = src_req;
      // level mode asserts while the synced pin is low, edge mode uses the flag
      req_raw[0] = ext_irq_trigger_type[0] ? ext_irq_request_flag[0] : ~pin_s2_q[0]; // R14
      req_raw[2] = ext_irq_trigger_type[1] ? ext_irq_request_flag[1] : ~pin_s2_q[1]; // R14
      en_all = {irq_enable_reg_b[`SRC_B_CNT-1:0], irq_enable_reg_a[`SRC_A_CNT-1:0]}; // R3
      plo_all = {prio_low_reg_b[`SRC_B_CNT-1:0], prio_low_reg_a[`SRC_A_CNT-1:0]};
      phi_all = {prio_high_reg_b[`SRC_B_CNT-1:0], prio_high_reg_a[`SRC_A_CNT-1:0]};
      pend = req_raw & en_all; // R2 R3
   end

   // arbitration: scan from lowest-ranked upward so index 0 wins ties
   reg [1:0] best_lvl;
   reg [3:0] best_idx;
   reg best_vld;
   reg [1:0] lvl_i;
   always @* begin
      best_lvl = 2'h0;
      best_idx = 4'h0;
      best_vld = 1'b0;
      lvl_i = 2'h0;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
         lvl_i = prio_of(phi_all, plo_all, i[3:0]); // R15 R5
         // ties keep the lower index, the fixed polling order
         if (pend[i] && (!best_vld || lvl_i >= best_lvl)) begin // R8 R9
            best_lvl = lvl_i;
            best_idx = i[3:0];
            best_vld = 1'b1;
         end
      end
   end

   wire [2:0] cur_svc;
   wire preempt_ok;
   assign cur_svc = svc_level(in_svc_q);
   // strictly higher level only; level 3 in service blocks all
   assign preempt_ok = ({1'b0, best_lvl} + 3'h1) > cur_svc; // R6 R7 R1
   wire grant;
   assign grant = best_vld && global_irq_enable && preempt_ok; // R4

   // wake: any enabled source in idle; external only in power-down
   wire wake_src;
   assign wake_src = (pwr_q[`PWR_IDLE] && |pend) ||
                     (pwr_q[`PWR_PDOWN] && (pend[0] || pend[2])); // R12 R13

   // wishbone decode
   wire wb_req;
   wire wb_wr;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // write lands on the edge where the master samples ack high
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   wire [7:0] adr;
   assign adr = wb_adr_i[7:0];

   reg [31:0] rd_d;
   always @* begin
      case (adr)
         `OFS_EN_A: rd_d = {24'h000000, irq_enable_reg_a};
         `OFS_EN_B: rd_d = {24'h000000, irq_enable_reg_b};
         `OFS_PRIO_LO_A: rd_d = {24'h000000, prio_low_reg_a};
         `OFS_PRIO_HI_A: rd_d = {24'h000000, prio_high_reg_a};
         `OFS_PRIO_LO_B: rd_d = {24'h000000, prio_low_reg_b};
         `OFS_PRIO_HI_B: rd_d = {24'h000000, prio_high_reg_b};
         `OFS_TCTRL: rd_d = {24'h000000, timer_control_reg};
         `OFS_STATUS: rd_d = {16'h0000, pend[11:0], 4'h0} >> 4;
         `OFS_SVC: rd_d = {20'h00000, best_vld, best_lvl, best_idx, in_svc_q, 1'b0};
         `OFS_IRQ_STAT: rd_d = {28'h0000000, ev_stat_q};
         `OFS_IRQ_MASK: rd_d = {28'h0000000, ev_mask_q};
         `OFS_PWR: rd_d = {30'h00000000, pwr_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   // edge detect reads the second sync stage and its delayed copy
   wire [1:0] fall;
   assign fall = pin_prev_q & ~pin_s2_q; // R11
   wire take;
   assign take = irq_req_q && vec_ack;
   // level of the vector the core is fetching, not of the current winner
   wire [1:0] vec_lvl;
   assign vec_lvl = prio_of(phi_all, plo_all, irq_vec_q);

   reg [3:0] ev_set;
   always @* begin
      ev_set = 4'h0;
      ev_set[`EV_VECTOR] = take;
      ev_set[`EV_WAKE] = wake_src;
      ev_set[`EV_EXT0] = fall[0] && ext_irq_trigger_type[0];
      ev_set[`EV_EXT1] = fall[1] && ext_irq_trigger_type[1];
   end

   reg [7:0] tc_d;
   always @* begin
      tc_d = timer_control_reg;
      if (wb_wr && adr == `OFS_TCTRL)
         tc_d = wb_dat_i[7:0];
      // taking the vector clears the edge flag, a new edge wins over it
      if (take && irq_vec_q == `SRC_EXT0 && ext_irq_trigger_type[0])
         tc_d[`TCTRL_IE0] = 1'b0; // R14
      if (take && irq_vec_q == `SRC_EXT1 && ext_irq_trigger_type[1])
         tc_d[`TCTRL_IE1] = 1'b0; // R14
      if (fall[0] && ext_irq_trigger_type[0])
         tc_d[`TCTRL_IE0] = 1'b1; // R10 R11
      if (fall[1] && ext_irq_trigger_type[1])
         tc_d[`TCTRL_IE1] = 1'b1; // R10 R11
   end

   // return clears the highest level in service
   reg [3:0] svc_clr;
   always @* begin
      svc_clr = 4'h0;
      case (cur_svc)
         3'h1: svc_clr = 4'h1;
         3'h2: svc_clr = 4'h2;
         3'h3: svc_clr = 4'h4;
         3'h4: svc_clr = 4'h8;
         default: svc_clr = 4'h0;
      endcase
   end

   // in-service stack: a take marks the level of the vector actually fetched
   reg [3:0] in_svc_d;
   always @* begin
      in_svc_d = in_svc_q;
      if (take)
         in_svc_d = in_svc_q | (4'h1 << vec_lvl); // R1 R6
      else if (reti)
         in_svc_d = in_svc_q & ~svc_clr;
   end

   // write-one-to-clear; a same-cycle event wins over the clear
   reg [`EV_W-1:0] ev_stat_d;
   always @* begin
      ev_stat_d = ev_stat_q;
      if (wb_wr && adr == `OFS_IRQ_STAT)
         ev_stat_d = ev_stat_q & ~wb_dat_i[`EV_W-1:0];
      ev_stat_d = ev_stat_d | ev_set;
   end

   // pin synchroniser; only the second stage and its delayed copy feed logic
   always @(posedge clk) begin
      if (srst) begin
         pin_s1_q <= 2'h3;
         pin_s2_q <= 2'h3;
         pin_prev_q <= 2'h3;
      end else begin
         pin_s1_q <= ext_irq_pin;
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // bus answer: one wait state, data returned only with ack
   always @(posedge clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_d : 32'h00000000;
      end
   end

   // enable and event mask registers
   always @(posedge clk) begin
      if (srst) begin
         irq_enable_reg_a <= 8'h00;
         irq_enable_reg_b <= 8'h00;
         ev_mask_q <= 4'h0;
      end else if (wb_wr) begin
         case (adr)
            `OFS_EN_A: irq_enable_reg_a <= lane_wr(irq_enable_reg_a, wb_dat_i, wb_sel_i);
            `OFS_EN_B: irq_enable_reg_b <= {3'h0, wb_dat_i[`SRC_B_CNT-1:0]};
            `OFS_IRQ_MASK: ev_mask_q <= wb_dat_i[`EV_W-1:0];
            default: ;
         endcase
      end
   end

   // priority registers
   always @(posedge clk) begin
      if (srst) begin
         prio_low_reg_a <= 8'h00;
         prio_high_reg_a <= 8'h00;
         prio_low_reg_b <= 8'h00;
         prio_high_reg_b <= 8'h00;
      end else if (wb_wr) begin
         case (adr)
            `OFS_PRIO_LO_A: prio_low_reg_a <= lane_wr(prio_low_reg_a, wb_dat_i, wb_sel_i);
            `OFS_PRIO_HI_A: prio_high_reg_a <= lane_wr(prio_high_reg_a, wb_dat_i, wb_sel_i);
            `OFS_PRIO_LO_B: prio_low_reg_b <= {3'h0, wb_dat_i[`SRC_B_CNT-1:0]};
            `OFS_PRIO_HI_B: prio_high_reg_b <= {3'h0, wb_dat_i[`SRC_B_CNT-1:0]};
            default: ;
         endcase
      end
   end

   // timer control and event status
   always @(posedge clk) begin
      if (srst) begin
         timer_control_reg <= 8'h00;
         ev_stat_q <= 4'h0;
         irq_q <= 1'b0;
      end else begin
         timer_control_reg <= tc_d;
         ev_stat_q <= ev_stat_d;
         // follows the status it is about to hold, so a clear drops it at once
         irq_q <= |(ev_stat_d & ev_mask_q);
      end
   end

   // power modes: software enters, a wake source leaves
   always @(posedge clk) begin
      if (srst) begin
         pwr_q <= 2'h0;
         wake_q <= 1'b0;
      end else begin
         if (wake_src)
            pwr_q <= 2'h0; // R12 R13
         else if (wb_wr && adr == `OFS_PWR)
            pwr_q <= wb_dat_i[1:0];
         wake_q <= wake_src;
      end
   end

   // request follows grant each cycle until the core takes it; vector may be upgraded meanwhile
   always @(posedge clk) begin
      if (srst) begin
         in_svc_q <= 4'h0;
         irq_req_q <= 1'b0;
         irq_vec_q <= 4'h0;
      end else begin
         in_svc_q <= in_svc_d;
         if (take) begin
            irq_req_q <= 1'b0;
         end else begin
            irq_req_q <= grant;
            irq_vec_q <= grant ? best_idx : irq_vec_q;
         end
      end
   end

endmodule // irq_ctrl

// ### verification/irq_ctrl_props.sv
module irq_ctrl_props #(
   parameter NSRC = 12
) (
   input wire clk,
   input wire srst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire vec_ack,
   input wire irq_req_q,
   input wire [3:0] irq_vec_q,
   input wire wake_q,
   input wire irq_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data off ack");
   property p_req_drop; irq_req_q && vec_ack |=> !irq_req_q; endproperty
   a_req_drop: assert property (p_req_drop) else $error("request kept");
   property p_vec_range; irq_req_q |-> irq_vec_q < NSRC; endproperty
   a_vec_range: assert property (p_vec_range) else $error("bad vector");
   property p_wake_pulse; wake_q |=> !wake_q; endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
   property p_reset; $fell(srst) |-> !irq_req_q && !irq_q && !wake_q && !wb_ack_o; endproperty
   a_reset: assert property (p_reset) else $error("outputs after reset");
endmodule // irq_ctrl_props

bind irq_ctrl irq_ctrl_props #(.NSRC(NSRC)) u_props (.clk(clk), .srst(srst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .vec_ack(vec_ack), .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q), .wake_q(wake_q),
   .irq_q(irq_q));

// ### verification/irq_core_model.sv
module irq_core_model (
   input wire clk,
   input wire srst,
   input wire irq_req,
   input wire [3:0] irq_vec,
   input wire [3:0] lag,
   output logic take,
   output logic [3:0] last_vec,
   output logic [7:0] taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;
   // a slow take lets the vector improve before it is fetched
   always @(posedge clk) begin
      if (srst) begin
         take <= 1'h0;
         wait_q <= 4'h0;
         taken <= 8'h00;
      end else if (take) begin
         take <= 1'h0;
         last_vec <= irq_vec;
         taken <= taken + 8'h01;
      end else if (irq_req && wait_q >= lag) begin
         take <= 1'h1;
         wait_q <= 4'h0;
      end else begin
         wait_q <= irq_req ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule // irq_core_model

// ### verification/irq_ctrl_tb_top.sv
`include "irq_ctrl_defines.vh"
module irq_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, wb_ack_o, vec_ack, irq_req_q, wake_q, irq_q;
   logic srst = 1'h1, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, reti = 1'h0;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, q;
   logic [3:0] irq_vec_q, last_vec, lag = 4'h0;
   logic [1:0] ext_irq_pin = 2'h3;
   logic [11:0] src_req = 12'h000;
   logic [7:0] taken, seen = 8'h00, wakes = 8'h00;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   irq_ctrl u_dut (.clk(clk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ext_irq_pin(ext_irq_pin), .src_req(src_req),
      .vec_ack(vec_ack), .reti(reti), .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q),
      .wake_q(wake_q), .irq_q(irq_q));
   irq_core_model u_core (.clk(clk), .srst(srst), .irq_req(irq_req_q), .irq_vec(irq_vec_q),
      .lag(lag), .take(vec_ack), .last_vec(last_vec), .taken(taken));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (wake_q === 1'h1) wakes <= wakes + 8'h01;
      if (cycles == 5000) begin
         mismatches++;
         summarize;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      wb_adr_i <= {24'h000000, a};
      wb_dat_i <= {24'h000000, d};
      wb_we_i <= w;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      @(posedge clk);
      while (wb_ack_o !== 1'h1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) mismatches++;
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 8'h00);
      chk(q, e);
   endtask
   task automatic vec(input logic [3:0] v);
      int n;
      n = 0;
      while (taken === seen && n < 60) begin
         @(posedge clk);
         n++;
      end
      if (n >= 60) mismatches++;
      seen = seen + 8'h01;
      chk({28'h0, last_vec}, {28'h0, v});
   endtask
   // no take may happen while blocked
   task automatic quiet;
      repeat (12) @(posedge clk);
      chk({24'h0, taken}, {24'h0, seen});
   endtask
   task automatic ret;
      reti <= 1'h1;
      @(posedge clk);
      reti <= 1'h0;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'h0;
      rdc(`OFS_EN_A, 32'h0);
      bus(1'h1, `OFS_PRIO_HI_A, 8'h20);
      rdc(`OFS_PRIO_HI_A, 32'h20);
      bus(1'h1, 8'h3C, 8'hFF);
      rdc(8'h3C, 32'h0);
      $display("test registers done");
      bus(1'h1, `OFS_EN_A, 8'hA8);
      bus(1'h1, `OFS_PRIO_LO_A, 8'h08);
      src_req <= 12'h028;
      vec(4'h5);
      quiet;
      bus(1'h1, `OFS_EN_B, 8'h03);
      bus(1'h1, `OFS_PRIO_LO_B, 8'h03);
      bus(1'h1, `OFS_PRIO_HI_B, 8'h03);
      src_req <= 12'h080;
      vec(4'h7);
      src_req <= 12'h100;
      quiet;
      ret;
      vec(4'h8);
      src_req <= 12'h000;
      ret;
      ret;
      $display("test nesting done");
      lag <= 4'h3;
      bus(1'h1, `OFS_EN_A, 8'hD0);
      bus(1'h1, `OFS_EN_B, 8'h04);
      bus(1'h1, `OFS_PRIO_LO_B, 8'h04);
      bus(1'h1, `OFS_PRIO_HI_B, 8'h00);
      src_req <= 12'h250;
      vec(4'h9);
      src_req <= 12'h050;
      ret;
      vec(4'h4);
      src_req <= 12'h000;
      ret;
      $display("test ties done");
      lag <= 4'h0;
      bus(1'h1, `OFS_PWR, 8'h01);
      bus(1'h1, `OFS_EN_A, 8'h10);
      src_req <= 12'h010;
      quiet;
      bus(1'h1, `OFS_EN_A, 8'h80);
      quiet;
      bus(1'h1, `OFS_EN_A, 8'h90);
      vec(4'h4);
      chk({24'h0, wakes}, 32'h1);
      src_req <= 12'h000;
      ret;
      $display("test enables done");
      bus(1'h1, `OFS_TCTRL, 8'h01);
      bus(1'h1, `OFS_EN_A, 8'h81);
      bus(1'h1, `OFS_PWR, 8'h02);
      ext_irq_pin <= 2'h2;
      vec(4'h0);
      rdc(`OFS_TCTRL, 32'h01);
      chk({24'h0, wakes}, 32'h2);
      ret;
      quiet;
      bus(1'h1, `OFS_TCTRL, 8'h00);
      vec(4'h0);
      ext_irq_pin <= 2'h3;
      repeat (4) @(posedge clk);
      ret;
      $display("test external done");
      bus(1'h1, `OFS_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk);
      chk({31'h0, irq_q}, 32'h1);
      rdc(`OFS_IRQ_STAT, 32'h07);
      bus(1'h1, `OFS_IRQ_STAT, 8'h01);
      repeat (2) @(posedge clk);
      chk({31'h0, irq_q}, 32'h0);
      rdc(`OFS_IRQ_STAT, 32'h06);
      $display("test events done");
      summarize;
   end
endmodule // irq_ctrl_tb_top
